// ==== rtl/dma_channel_request_arbiter.sv ====
// Four-channel DMA request sampling, arbitration and channel registers
`timescale 1ns/1ps
module dma_channel_request_arbiter (
  input wire logic clk,
  input wire logic srst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [63:0] req_lines,
  input wire logic xfer_done,
  input wire logic cpu_access_done,
  output logic bus_grant,
  output logic [1:0] grant_ch,
  output logic irq
);

  localparam int NCH = dma_arb_pkg::NCH;
  localparam int AW = dma_arb_pkg::ADDR_W;

  // Bus clock divider
  logic [3:0] bclk_cnt;
  logic bclk_en;

  // Address decode
  logic [NCH-1:0] ctrl_wr;
  logic [NCH-1:0] src_wr;
  logic [NCH-1:0] tcrl_wr;
  logic [NCH-1:0] tcrh_wr;
  logic [NCH-1:0] icr_wr;
  logic stat_wr;
  logic mask_wr;

  // Per-channel state gathered for the arbiter and readback
  logic [NCH-1:0] eligible;
  logic [NCH-1:0] grant_now;
  logic [NCH-1:0] done_ch;
  logic [NCH-1:0] underflow;
  dma_arb_pkg::chan_ctrl_s ctl_v [NCH];
  dma_arb_pkg::src_sel_s src_v [NCH];
  logic [15:0] cnt_v [NCH];
  logic [7:0] icr_v [NCH];

  // Arbiter
  dma_arb_pkg::arb_state_e state;
  logic any_elig;
  logic [1:0] pick_idx;

  // Interrupt status and mask
  logic [NCH-1:0] irq_stat;
  logic [NCH-1:0] irq_mask;

  logic [7:0] read_val;

  // One-cycle enable at the end of each bus-clock period
  always_ff @(posedge clk) begin
    if (srst) begin
      bclk_cnt <= 4'h0;
      bclk_en <= 1'b0;
    end else if (bclk_cnt == dma_arb_pkg::BCLK_DIV - 4'h1) begin
      bclk_cnt <= 4'h0;
      bclk_en <= 1'b1;
    end else begin
      bclk_cnt <= bclk_cnt + 4'h1;
      bclk_en <= 1'b0;
    end
  end

  always_comb begin
    ctrl_wr = '0;
    src_wr = '0;
    tcrl_wr = '0;
    tcrh_wr = '0;
    icr_wr = '0;
    for (int c = 0; c < NCH; c++) begin
      ctrl_wr[c] = wr && (addr == dma_arb_pkg::CTRL_BASE + AW'(c));
      src_wr[c] = wr && (addr == dma_arb_pkg::SRC_BASE + AW'(c));
      tcrl_wr[c] = wr && (addr == dma_arb_pkg::TCR_LO_BASE + AW'(c));
      tcrh_wr[c] = wr && (addr == dma_arb_pkg::TCR_HI_BASE + AW'(c));
      icr_wr[c] = wr && (addr == dma_arb_pkg::IRQ_CTRL_OFS[c]);
    end
    stat_wr = wr && (addr == dma_arb_pkg::IRQ_STAT_OFS);
    mask_wr = wr && (addr == dma_arb_pkg::IRQ_MASK_OFS);
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      dma_arb_pkg::chan_ctrl_s ctl;
      dma_arb_pkg::src_sel_s src;
      dma_arb_pkg::src_sel_s src_new;
      logic [15:0] reload;
      logic [15:0] counter;
      logic [7:0] icr;
      logic seen;
      logic chan_req;
      logic src_change;
      logic sw_trig;
      logic pend_set;
      logic pend_clr;
      logic at_zero;

      assign src_new.group = wdata[dma_arb_pkg::SRC_GROUP_BIT];
      assign src_new.field = wdata[dma_arb_pkg::SRC_FIELD_LSB +: dma_arb_pkg::FIELD_W];
      assign chan_req = req_lines[{src.group, src.field}];
      assign src_change = src_wr[g] && (src_new != src); // R6
      assign sw_trig = src_wr[g] && wdata[dma_arb_pkg::SRC_SWTRIG_BIT];
      assign at_zero = (counter == 16'h0000);

      always_ff @(posedge clk) begin
        if (srst) begin
          src <= dma_arb_pkg::SRC_RST;
        end else if (src_wr[g]) begin
          src <= src_new;
        end
      end

      // Requests seen anywhere in the period count once at its end
      always_ff @(posedge clk) begin
        if (srst || bclk_en) begin
          seen <= 1'b0;
        end else if (chan_req) begin
          seen <= 1'b1;
        end
      end

      // Set regardless of enable; all channels of one period together
      assign pend_set = (bclk_en && (seen || chan_req)) || src_change || sw_trig; // R1 R13
      // A written 1 has no effect, a written 0 clears
      assign pend_clr = grant_now[g] || (ctrl_wr[g] && !wdata[dma_arb_pkg::CTRL_PEND_BIT]); // R8 R13

      always_ff @(posedge clk) begin
        if (srst) begin
          ctl.pending <= 1'b0;
        end else begin
          ctl.pending <= (ctl.pending && !pend_clr) || pend_set; // R5
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          ctl.enable <= dma_arb_pkg::CTRL_RST.enable;
          ctl.repeat_mode <= dma_arb_pkg::CTRL_RST.repeat_mode;
        end else if (ctrl_wr[g]) begin
          ctl.enable <= wdata[dma_arb_pkg::CTRL_EN_BIT];
          ctl.repeat_mode <= wdata[dma_arb_pkg::CTRL_REPEAT_BIT];
        end else if (done_ch[g] && at_zero && !ctl.repeat_mode) begin
          ctl.enable <= 1'b0; // R14
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          reload <= dma_arb_pkg::TCR_RST;
        end else if (tcrl_wr[g]) begin
          reload[7:0] <= wdata;
        end else if (tcrh_wr[g]) begin
          reload[15:8] <= wdata;
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          counter <= dma_arb_pkg::TCR_RST;
        end else if (ctrl_wr[g] && wdata[dma_arb_pkg::CTRL_EN_BIT]) begin
          counter <= reload; // R11
        end else if (done_ch[g]) begin
          if (at_zero && ctl.repeat_mode) begin
            counter <= reload; // R14
          end else begin
            counter <= counter - 16'h0001; // R11
          end
        end
      end

      // Only the low bits have a defined reset value
      always_ff @(posedge clk) begin
        if (srst) begin
          icr[dma_arb_pkg::IRQ_CTRL_LOW_W-1:0] <= dma_arb_pkg::IRQ_CTRL_RST[dma_arb_pkg::IRQ_CTRL_LOW_W-1:0]; // R12
        end else if (icr_wr[g]) begin
          icr[dma_arb_pkg::IRQ_CTRL_LOW_W-1:0] <= wdata[dma_arb_pkg::IRQ_CTRL_LOW_W-1:0];
        end
      end

      always_ff @(posedge clk) begin
        if (icr_wr[g]) begin
          icr[7:dma_arb_pkg::IRQ_CTRL_LOW_W] <= wdata[7:dma_arb_pkg::IRQ_CTRL_LOW_W];
        end
      end

      assign eligible[g] = ctl.enable && ctl.pending;
      assign underflow[g] = done_ch[g] && at_zero;
      assign ctl_v[g] = ctl;
      assign src_v[g] = src;
      assign cnt_v[g] = counter;
      assign icr_v[g] = icr;
    end
  endgenerate

  dma_prio_pick u_pick (
    .req(eligible),
    .any(any_elig),
    .idx(pick_idx)
  );

  // Grant is taken only in the idle state, after the processor access
  always_comb begin
    grant_now = '0;
    done_ch = '0;
    if (state == dma_arb_pkg::ARB_IDLE && any_elig) begin
      grant_now[pick_idx] = 1'b1; // R2 R15
    end
    if (state == dma_arb_pkg::ARB_XFER && xfer_done) begin
      done_ch[grant_ch] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= dma_arb_pkg::ARB_IDLE;
      bus_grant <= 1'b0;
      grant_ch <= 2'h0;
    end else begin
      case (state)
        dma_arb_pkg::ARB_IDLE: begin
          if (any_elig) begin
            state <= dma_arb_pkg::ARB_XFER;
            bus_grant <= 1'b1;
            grant_ch <= pick_idx;
          end
        end
        dma_arb_pkg::ARB_XFER: begin
          // A grant ends after exactly one unit, no pre-emption meanwhile
          if (xfer_done) begin
            state <= dma_arb_pkg::ARB_CPU; // R4 R15
            bus_grant <= 1'b0;
          end
        end
        dma_arb_pkg::ARB_CPU: begin
          if (cpu_access_done) begin
            state <= dma_arb_pkg::ARB_IDLE; // R3
          end
        end
        default: begin
          state <= dma_arb_pkg::ARB_IDLE;
          bus_grant <= 1'b0;
        end
      endcase
    end
  end

  // Underflow events are sticky; a new event beats a clearing write
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat <= dma_arb_pkg::IRQ_STAT_RST;
    end else begin
      irq_stat <= (irq_stat & ~(stat_wr ? wdata[NCH-1:0] : 4'h0)) | underflow;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask <= dma_arb_pkg::IRQ_MASK_RST;
    end else if (mask_wr) begin
      irq_mask <= wdata[NCH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  always_comb begin
    read_val = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      if (addr == dma_arb_pkg::CTRL_BASE + AW'(c)) begin
        read_val[dma_arb_pkg::CTRL_REPEAT_BIT] = ctl_v[c].repeat_mode;
        read_val[dma_arb_pkg::CTRL_PEND_BIT] = ctl_v[c].pending;
        read_val[dma_arb_pkg::CTRL_EN_BIT] = ctl_v[c].enable;
      end
      if (addr == dma_arb_pkg::SRC_BASE + AW'(c)) begin
        read_val[dma_arb_pkg::SRC_FIELD_LSB +: dma_arb_pkg::FIELD_W] = src_v[c].field;
        read_val[dma_arb_pkg::SRC_GROUP_BIT] = src_v[c].group;
      end
      if (addr == dma_arb_pkg::TCR_LO_BASE + AW'(c)) begin
        read_val = cnt_v[c][7:0];
      end
      if (addr == dma_arb_pkg::TCR_HI_BASE + AW'(c)) begin
        read_val = cnt_v[c][15:8];
      end
      if (addr == dma_arb_pkg::IRQ_CTRL_OFS[c]) begin
        read_val = icr_v[c];
      end
    end
    if (addr == dma_arb_pkg::IRQ_STAT_OFS) begin
      read_val[NCH-1:0] = irq_stat;
    end
    if (addr == dma_arb_pkg::IRQ_MASK_OFS) begin
      read_val[NCH-1:0] = irq_mask;
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= read_val;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // dma_channel_request_arbiter

// ==== rtl/dma_arb_pkg.sv ====
// Constants, types and register map of the DMA request arbiter
// How it works
// R1: Requests sampled once per bus-clock period
// R2: Fixed priority: channel 0 highest, 3 lowest
// R3: Processor gets one access between transfers
// R4: One grant covers exactly one transfer
// R5: One pending flag per channel, no counting
// R6: Source selection change may set pending flag
// R7: Software clears pending after source change
// R8: Writing 1 keeps pending, 0 clears it
// R9: Software rewrites enable with pending, then verifies
// R10: Read-modify-write of enable writes pending as 1
// R11: Enable write reloads counter from written value
// R12: Four interrupt control registers, low bits reset
// R13: Pending set always; cleared just before transfer
// R14: Underflow stops single mode, reloads repeat mode
// R15: No pre-emption; arbitrate only between transfers
package dma_arb_pkg;

  localparam int NCH = 4;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int TCR_W = 16;
  localparam int FIELD_W = 5;
  localparam int NREQ = 64;

  // Interrupt control register offsets, index 0 is channel 0
  localparam logic [3:0][9:0] IRQ_CTRL_OFS = {10'h06a, 10'h069, 10'h04c, 10'h04b};
  localparam int IRQ_CTRL_LOW_W = 3;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;

  // Channel registers, one byte per channel from each base
  localparam logic [9:0] CTRL_BASE = 10'h380;
  localparam logic [9:0] SRC_BASE = 10'h384;
  localparam logic [9:0] TCR_LO_BASE = 10'h388;
  localparam logic [9:0] TCR_HI_BASE = 10'h38c;
  localparam logic [9:0] IRQ_STAT_OFS = 10'h390;
  localparam logic [9:0] IRQ_MASK_OFS = 10'h391;

  // Channel control register fields
  localparam int CTRL_REPEAT_BIT = 0;
  localparam int CTRL_PEND_BIT = 3;
  localparam int CTRL_EN_BIT = 4;

  // Source select register fields
  localparam int SRC_FIELD_LSB = 0;
  localparam int SRC_GROUP_BIT = 6;
  localparam int SRC_SWTRIG_BIT = 7;

  localparam logic [TCR_W-1:0] TCR_RST = 16'h0000;
  localparam logic [NCH-1:0] IRQ_STAT_RST = 4'h0;
  localparam logic [NCH-1:0] IRQ_MASK_RST = 4'h0;

  // Bus clock is the system clock divided by this count
  localparam logic [3:0] BCLK_DIV = 4'h2;

  typedef struct packed {
    logic repeat_mode;
    logic enable;
    logic pending;
  } chan_ctrl_s;

  typedef struct packed {
    logic group;
    logic [FIELD_W-1:0] field;
  } src_sel_s;

  localparam chan_ctrl_s CTRL_RST = '{repeat_mode: 1'b0, enable: 1'b0, pending: 1'b0};
  localparam src_sel_s SRC_RST = '{group: 1'b0, field: 5'h00};

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_XFER,
    ARB_CPU
  } arb_state_e;

endpackage

// ==== rtl/dma_prio_pick.sv ====
// Fixed-priority picker: lowest index wins
`timescale 1ns/1ps
module dma_prio_pick (
  input wire logic [3:0] req,
  output logic any,
  output logic [1:0] idx
);

  always_comb begin
    any = 1'b0;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i]) begin // R2
        any = 1'b1;
        idx = 2'(i);
      end
    end
  end

endmodule // dma_prio_pick

// ==== tb/dma_arb_asserts.sv ====
// Port-level assertions for the DMA request arbiter
`timescale 1ns/1ps
module dma_arb_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [63:0] req_lines,
  input wire logic xfer_done,
  input wire logic cpu_access_done,
  input wire logic bus_grant,
  input wire logic [1:0] grant_ch,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_one_xfer: assert property (bus_grant && xfer_done |=> !bus_grant)
    else $error("grant outlived transfer");
  a_no_preempt: assert property (bus_grant && !xfer_done |=> bus_grant && $stable(grant_ch))
    else $error("transfer cut short");
  a_cpu_gap: assert property ($fell(bus_grant) |-> !bus_grant [*2])
    else $error("no processor slot");
  a_cpu_wait: assert property ($fell(bus_grant) && !$past(srst) && !cpu_access_done ##1
    !cpu_access_done [*3] |-> !bus_grant)
    else $error("grant before processor access");
  a_ch_hold: assert property (!bus_grant ##1 !bus_grant |-> $stable(grant_ch))
    else $error("channel changed while idle");
  a_rdata_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_read: assert property (rd && addr == 10'h3ff |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($past(srst) |-> !bus_grant && !irq && rdata == 8'h00)
    else $error("outputs active after reset");
endmodule // dma_arb_asserts

bind dma_channel_request_arbiter dma_arb_asserts i_dma_arb_asserts (.clk(clk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .req_lines(req_lines), .xfer_done(xfer_done),
  .cpu_access_done(cpu_access_done), .bus_grant(bus_grant), .grant_ch(grant_ch), .irq(irq));

// ==== tb/cpu_bus_model.sv ====
// Processor and datapath model: ends each transfer, then takes one bus access
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic bus_grant,
  input wire logic [2:0] dly,
  output logic xfer_done,
  output logic cpu_access_done
);
  logic [2:0] cnt;
  logic cpu_due;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 3'h0;
      cpu_due <= 1'b0;
      xfer_done <= 1'b0;
      cpu_access_done <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      cpu_access_done <= 1'b0;
      cnt <= cnt + 3'h1;
      if (bus_grant && !xfer_done && cnt >= dly) begin
        xfer_done <= 1'b1;
        cpu_due <= 1'b1;
        cnt <= 3'h0;
      end else if (cpu_due && !bus_grant && cnt >= dly) begin
        cpu_access_done <= 1'b1;
        cpu_due <= 1'b0;
      end else if (!bus_grant && !cpu_due) begin
        cnt <= 3'h0;
      end
    end
  end
endmodule // cpu_bus_model

// ==== tb/dma_channel_request_arbiter_test.sv ====
// Self-checking bench for the DMA request arbiter
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module dma_channel_request_arbiter_test;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, gprev = 1'b0;
  logic xfer_done, cpu_access_done, bus_grant, irq;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [63:0] req_lines = 64'h0;
  logic [1:0] grant_ch;
  logic [2:0] dly = 3'h5;
  logic [1:0] gq[$];
  int failures = 0;
  int checked = 0;
  logic [9:0] ra[6] = '{10'h04b, 10'h04c, 10'h069, 10'h06a, 10'h391, 10'h3ff};
  logic [7:0] rw[6] = '{8'ha5, 8'h5a, 8'hff, 8'h00, 8'hff, 8'h55};
  logic [7:0] rx[6] = '{8'ha5, 8'h5a, 8'hff, 8'h00, 8'h0f, 8'h00};
  localparam logic [9:0] ctl = dma_arb_pkg::CTRL_BASE;
  localparam logic [9:0] lo2 = dma_arb_pkg::TCR_LO_BASE + 10'h002;
  localparam logic [9:0] stat = dma_arb_pkg::IRQ_STAT_OFS;
  localparam logic [9:0] mask = dma_arb_pkg::IRQ_MASK_OFS;
  dma_channel_request_arbiter i_dma_channel_request_arbiter (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .req_lines(req_lines), .xfer_done(xfer_done),
    .cpu_access_done(cpu_access_done), .bus_grant(bus_grant), .grant_ch(grant_ch), .irq(irq));
  cpu_bus_model i_cpu_bus_model (.clk(clk), .srst(srst), .bus_grant(bus_grant), .dly(dly),
    .xfer_done(xfer_done), .cpu_access_done(cpu_access_done));
  initial forever #50 clk = ~clk;
  // Record the channel of every new grant
  always @(posedge clk) begin
    if (bus_grant === 1'b1 && gprev !== 1'b1) gq.push_back(grant_ch);
    gprev <= bus_grant;
  end
  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // One idle edge keeps back-to-back writes from driving wr twice in one step
    @(posedge clk);
  endtask
  task automatic reg_rd(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, rdata & m)
    @(posedge clk);
  endtask
  task automatic pulse(input logic [63:0] v);
    req_lines <= v;
    @(posedge clk);
    req_lines <= 64'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_grants(input int n);
    for (int k = 0; k < 300 && gq.size() < n; k++) @(posedge clk);
    if (gq.size() < n) begin
      failures++;
      print_verdict();
    end
    repeat (16) @(posedge clk);
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(negedge clk);
    `CHK("irq", e, irq)
    @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) reg_rd(dma_arb_pkg::IRQ_CTRL_OFS[i], 8'h00, 8'h07);
    for (int i = 0; i < 6; i++) begin
      reg_wr(ra[i], rw[i]);
      reg_rd(ra[i], rx[i], 8'hff);
    end
    // Sources 0..3, then enable every channel with its pending flag cleared
    for (int i = 1; i < 4; i++) reg_wr(dma_arb_pkg::SRC_BASE + 10'(i), 8'(i));
    for (int i = 0; i < 4; i++) reg_wr(ctl + 10'(i), 8'h10);
    pulse(64'hf);
    pulse(64'h8);
    wait_grants(4);
    repeat (40) @(posedge clk);
    `CHK("grants", 4, gq.size())
    for (int i = 0; i < 4; i++) `CHK("grant_ch", 2'(i), gq[i])
    reg_rd(stat, 8'h0f, 8'hff);
    reg_rd(ctl, 8'h00, 8'hff);
    reg_rd(dma_arb_pkg::TCR_HI_BASE + 10'h003, 8'hff, 8'hff);
    chk_irq(1'b1);
    reg_wr(mask, 8'h00);
    chk_irq(1'b0);
    reg_wr(stat, 8'h0f);
    reg_rd(stat, 8'h00, 8'hff);
    dly <= 3'h0;
    reg_wr(dma_arb_pkg::SRC_BASE + 10'h001, 8'h09);
    reg_rd(ctl + 10'h001, 8'h08, 8'hff);
    reg_wr(ctl + 10'h001, 8'h08);
    reg_rd(ctl + 10'h001, 8'h08, 8'hff);
    reg_wr(ctl + 10'h001, 8'h00);
    reg_rd(ctl + 10'h001, 8'h00, 8'hff);
    reg_wr(ctl + 10'h001, 8'h08);
    reg_rd(ctl + 10'h001, 8'h00, 8'hff);
    pulse(64'h200);
    reg_rd(ctl + 10'h001, 8'h08, 8'hff);
    reg_wr(ctl + 10'h001, 8'h00);
    reg_wr(lo2, 8'h01);
    reg_wr(dma_arb_pkg::TCR_HI_BASE + 10'h002, 8'h00);
    reg_wr(ctl + 10'h002, 8'h10);
    reg_rd(lo2, 8'h01, 8'hff);
    pulse(64'h4);
    wait_grants(5);
    reg_rd(lo2, 8'h00, 8'hff);
    reg_wr(ctl + 10'h002, 8'h11);
    pulse(64'h4);
    wait_grants(6);
    pulse(64'h4);
    wait_grants(7);
    reg_rd(lo2, 8'h01, 8'hff);
    reg_rd(ctl + 10'h002, 8'h11, 8'hff);
    `CHK("grant_ch", 2'h2, gq[6])
    reg_wr(ctl + 10'h002, 8'h19);
    reg_rd(lo2, 8'h01, 8'hff);
    reg_wr(mask, 8'h04);
    chk_irq(1'b1);
    reg_wr(stat, 8'h04);
    chk_irq(1'b0);
    // Read-modify-write of enable keeps a waiting request by writing pending as 1
    pulse(64'h200);
    reg_rd(ctl + 10'h001, 8'h08, 8'hff);
    reg_wr(ctl + 10'h001, 8'h18);
    wait_grants(8);
    `CHK("grant_ch", 2'h1, gq[7])
    reg_rd(ctl + 10'h001, 8'h00, 8'hff);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    reg_rd(dma_arb_pkg::IRQ_CTRL_OFS[0], 8'h00, 8'h07);
    reg_rd(stat, 8'h00, 8'hff);
    print_verdict();
  end
endmodule // dma_channel_request_arbiter_test
